//--- shared/tpc_defines.svh
// Purpose: Offsets, field positions, reset values and fixed counts for the timer prescaler and compare outputs.
// Assumes: Included by its bare name wherever one of these names is used.
// Notes:   Byte addresses are for a 32-bit register bus, one aligned word per register.
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

// Register byte addresses.
`define TPC_OFF_CTRL_A      32'h0000_00b0
`define TPC_OFF_CTRL_B      32'h0000_00b4
`define TPC_OFF_CMP_A       32'h0000_00b8
`define TPC_OFF_CMP_B       32'h0000_00bc
`define TPC_OFF_ASYNC_STAT  32'h0000_00c0
`define TPC_OFF_GEN_CTRL    32'h0000_00c4
`define TPC_OFF_COUNT       32'h0000_00c8

// Reset values.
`define TPC_RST_BYTE        8'h00
`define TPC_RST_WORD        32'h0000_0000

// Control register A fields.
`define TPC_COMA_MSB        7
`define TPC_COMA_LSB        6
`define TPC_COMB_MSB        5
`define TPC_COMB_LSB        4
`define TPC_WGML_MSB        1
`define TPC_WGML_LSB        0
`define TPC_CTRL_A_WMASK    8'hf3

// Control register B fields.
`define TPC_FORCE_A_BIT     7
`define TPC_FORCE_B_BIT     6
`define TPC_WGM_TOP_BIT     3
`define TPC_CS_MSB          2
`define TPC_CS_LSB          0

// Asynchronous status and general control fields.
`define TPC_EXTERNAL_CLOCK_ENABLE_BIT       6
`define TPC_ASYNC_BIT       5
`define TPC_PSR_BIT         1

// Counter limits.
`define TPC_MAX             8'hff
`define TPC_BOTTOM          8'h00

// Compare output mode codes.
`define TPC_COM_OFF         2'h0
`define TPC_COM_TOGGLE      2'h1
`define TPC_COM_CLEAR       2'h2
`define TPC_COM_SET         2'h3

// Prescaler depth and clock-select codes.
`define TPC_DIV_BITS        10
`define TPC_CS_STOP         3'h0
`define TPC_CS_DIRECT       3'h1
`define TPC_CS_FIRST_TAP    3'h2

`endif

//--- shared/tpc_pkg.sv
// Purpose: Types shared by the timer prescaler and compare-output block.
// Assumes: Offsets and field positions live in tpc_defines.svh.
// Notes:   Waveform kinds follow the three-bit waveform mode value.
package tpc_pkg;

	// Three-bit waveform mode values.
	typedef enum logic [2:0] {
		WGM_NORMAL    = 3'h0,
		WGM_PHASE_FF  = 3'h1,
		WGM_CTC       = 3'h2,
		WGM_FAST_FF   = 3'h3,
		WGM_RSVD4     = 3'h4,
		WGM_PHASE_CMP = 3'h5,
		WGM_RSVD6     = 3'h6,
		WGM_FAST_CMP  = 3'h7
	} tpc_wgm_t;

	// Bus slave states.
	typedef enum {ST_IDLE, ST_WRITE, ST_READ_WAIT, ST_READ_DONE} tpc_bus_st_t;

	// One compare output pin as seen by the port logic.
	typedef struct packed {
		logic value;
		logic oe;
		logic override_port;
	} tpc_pin_t;

	// Oscillator pin control group.
	typedef struct packed {
		logic pins_detach;
		logic crystal_enable;
		logic ext_buf_enable;
	} tpc_osc_ctl_t;

endpackage : tpc_pkg

//--- design/tpc_prescaler.sv
// Purpose: Free-running prescaler producing one-cycle count enables from the source clock ticks.
// Assumes: src_tick is a one-cycle pulse on hclk, one per source clock period.
// Notes:   A reset strobe clears the divider so that the next divided tick has a known phase.
`timescale 1ns/1ps
`include "tpc_defines.svh"

module tpc_prescaler #(
	parameter int DIV_BITS = `TPC_DIV_BITS
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       ce,
	input  wire logic       src_tick,
	input  wire logic       psr,
	input  wire logic [2:0] clock_select_field,
	output logic            count_enable
);
	import tpc_pkg::*;

	localparam int NTAP = 6;
	localparam int TAP_BITS [NTAP] = '{3, 5, 6, 7, 8, 10};

	logic [DIV_BITS-1:0] div_r;
	logic [DIV_BITS-1:0] div_nxt;
	logic [NTAP-1:0]     tap_tick;
	logic [2:0]          tap_sel;

	// Divider advances once per source tick; the reset strobe wins over counting. [R6] [R18]
	always_comb begin
		div_nxt = div_r;
		if (psr) begin
			div_nxt = '0; // [R6]
		end else if (src_tick) begin
			div_nxt = div_r + {{(DIV_BITS-1){1'b0}}, 1'b1}; // [R18]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_r <= '0;
		end else if (ce) begin
			div_r <= div_nxt;
		end
	end

	// Each tap fires when its low divider bits are all ones, so /8 ... /1024 come from one counter. [R5]
	genvar gi;
	generate
		for (gi = 0; gi < NTAP; gi++) begin : g_tap
			assign tap_tick[gi] = src_tick & !psr & (&div_r[TAP_BITS[gi]-1:0]); // [R5]
		end
	endgenerate

	assign tap_sel = clock_select_field - `TPC_CS_FIRST_TAP;

	// Clock-select decode: stop, undivided, or one of the six taps. [R17]
	always_comb begin
		case (clock_select_field)
			`TPC_CS_STOP:   count_enable = 1'b0; // [R17]
			`TPC_CS_DIRECT: count_enable = src_tick; // [R17]
			default:        count_enable = tap_tick[tap_sel]; // [R17]
		endcase
	end

endmodule : tpc_prescaler

//--- design/tpc_top.sv
// Purpose: Timer clock-source selection, prescaler and two compare-output channels behind an AHB-Lite slave.
// Assumes: hclk is the I/O clock; timer_osc_in is an asynchronous pin; direction bits come from port logic on hclk.
// Notes:   The oscillator pin is synchronised and edge detected, so it must run below a quarter of hclk.
//
// Overview of operation
// R1: After reset the timer runs from the I/O clock.
// R2: Asynchronous-select set makes the oscillator pin the timer source clock.
// R3: Asynchronous-select set detaches both oscillator pins from their port function.
// R4: External-clock-enable accepts an applied clock instead of running the crystal.
// R5: Prescaler offers /8, /32, /64, /128, /256, /1024, undivided and stop.
// R6: Writing one to prescaler reset clears the prescaler count.
// R7: Control A: chan A mode 7:6, chan B 5:4, waveform low 1:0, 3:2 zero.
// R8: Nonzero output mode overrides the port; pin driven only if direction is output.
// R9: Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// R10: Fast PWM chan A: 01 toggles only with top bit; 10/11 clear/set, inverse at BOTTOM.
// R11: Fast PWM chan B: 01 reserved; 10 and 11 as non-inverting and inverting.
// R12: Fast PWM, compare equals TOP with mode high bit: ignore match, act at BOTTOM.
// R13: Phase-correct chan A: 10 clear up set down, 11 reverse, 01 toggles with top bit.
// R14: Phase-correct chan B: 01 reserved, 10/11 like chan A, 00 off.
// R15: Phase-correct, compare equals TOP with mode high bit: ignore match, act at TOP.
// R16: Waveform modes 0 normal, 1/5 phase, 2 CTC, 3/7 fast; 4 and 6 reserved.
// R17: Clock select 000 stop, 001 undivided, 010..111 /8 to /1024.
// R18: Prescaler is a free counter giving one-cycle count enables at the chosen ratio.
`timescale 1ns/1ps
`include "tpc_defines.svh"

module tpc_top (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          ce,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic [31:0]        hrdata,
	output logic               hresp,
	input  wire logic          timer_osc_in,
	input  wire logic          dir_out_a,
	input  wire logic          dir_out_b,
	output tpc_pkg::tpc_pin_t  compare_out_a,
	output tpc_pkg::tpc_pin_t  compare_out_b,
	output tpc_pkg::tpc_osc_ctl_t osc_ctl
);
	import tpc_pkg::*;

	tpc_bus_st_t st_r, st_nxt;
	logic [31:0] addr_r, addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic [31:0] rd_mux;
	logic        take;
	logic        wr_do;

	logic [7:0]  ctrl_a_r, ctrl_a_nxt;
	logic        wgm_top_r, wgm_top_nxt;
	logic [2:0]  cs_r, cs_nxt;
	logic [7:0]  cmp_a_r, cmp_a_nxt;
	logic [7:0]  cmp_b_r, cmp_b_nxt;
	logic        external_clock_enable_r, external_clock_enable_nxt;
	logic        async_r, async_nxt;
	logic        psr;
	logic [1:0]  force_cmp;

	logic        osc_s1_r, osc_s2_r, osc_s3_r;
	logic        src_tick;
	logic        cnt_en;

	logic [7:0]  cnt_r, cnt_nxt;
	logic        up_r, up_nxt;
	logic        block_r, block_nxt;
	logic [7:0]  top;
	logic        at_top;
	tpc_wgm_t    wgm;
	logic        is_fast;
	logic        is_phase;

	logic [1:0]  com [2];
	logic [7:0]  cmp [2];
	logic [1:0]  oc_r;
	logic [1:0]  oc_nxt;
	logic [1:0]  ovr;
	logic [1:0]  dir_bit;

	// Bus takes an address phase only when the slave is selected, the transfer is real and the bus is ready.
	assign take  = ce & hsel & htrans[1] & hready;
	assign wr_do = ce & (st_r == ST_WRITE);
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	// Reads spend one wait cycle so that read data leave a flip-flop and see any write just before.
	assign hreadyout = (st_r != ST_READ_WAIT);

	// Read mux over the register state; reserved and unmapped words read as zero. [R7]
	always_comb begin
		case (addr_r)
			`TPC_OFF_CTRL_A:     rd_mux = {24'h00_0000, ctrl_a_r}; // [R7]
			`TPC_OFF_CTRL_B:     rd_mux = {28'h000_0000, wgm_top_r, cs_r};
			`TPC_OFF_CMP_A:      rd_mux = {24'h00_0000, cmp_a_r};
			`TPC_OFF_CMP_B:      rd_mux = {24'h00_0000, cmp_b_r};
			`TPC_OFF_ASYNC_STAT: rd_mux = {25'h000_0000, external_clock_enable_r, async_r, 5'h00};
			`TPC_OFF_COUNT:      rd_mux = {24'h00_0000, cnt_r};
			default:             rd_mux = `TPC_RST_WORD;
		endcase
	end

	// Bus state machine next values.
	always_comb begin
		st_nxt     = st_r;
		addr_nxt   = addr_r;
		hrdata_nxt = hrdata_r;
		case (st_r)
			ST_READ_WAIT: begin
				hrdata_nxt = rd_mux;
				st_nxt     = ST_READ_DONE;
			end
			default: begin
				if (take) begin
					addr_nxt = haddr;
					st_nxt   = hwrite ? ST_WRITE : ST_READ_WAIT;
				end else begin
					st_nxt = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r     <= ST_IDLE;
			addr_r   <= `TPC_RST_WORD;
			hrdata_r <= `TPC_RST_WORD;
		end else if (ce) begin
			st_r     <= st_nxt;
			addr_r   <= addr_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end

	// Strobes raised by a write: prescaler reset and forced compares, which read back as zero. [R6]
	assign psr          = wr_do & (addr_r == `TPC_OFF_GEN_CTRL) & hwdata[`TPC_PSR_BIT]; // [R6]
	assign force_cmp[0] = wr_do & (addr_r == `TPC_OFF_CTRL_B) & hwdata[`TPC_FORCE_A_BIT];
	assign force_cmp[1] = wr_do & (addr_r == `TPC_OFF_CTRL_B) & hwdata[`TPC_FORCE_B_BIT];

	// Configuration registers; bits 3:2 of control A stay zero. [R7]
	always_comb begin
		ctrl_a_nxt  = ctrl_a_r;
		wgm_top_nxt = wgm_top_r;
		cs_nxt      = cs_r;
		cmp_a_nxt   = cmp_a_r;
		cmp_b_nxt   = cmp_b_r;
		external_clock_enable_nxt   = external_clock_enable_r;
		async_nxt   = async_r;
		if (wr_do) begin
			case (addr_r)
				`TPC_OFF_CTRL_A: ctrl_a_nxt = hwdata[7:0] & `TPC_CTRL_A_WMASK; // [R7]
				`TPC_OFF_CTRL_B: begin
					wgm_top_nxt = hwdata[`TPC_WGM_TOP_BIT];
					cs_nxt      = hwdata[`TPC_CS_MSB:`TPC_CS_LSB];
				end
				`TPC_OFF_CMP_A: cmp_a_nxt = hwdata[7:0];
				`TPC_OFF_CMP_B: cmp_b_nxt = hwdata[7:0];
				`TPC_OFF_ASYNC_STAT: begin
					external_clock_enable_nxt = hwdata[`TPC_EXTERNAL_CLOCK_ENABLE_BIT]; // [R4]
					async_nxt = hwdata[`TPC_ASYNC_BIT]; // [R2]
				end
				default: begin
				end
			endcase
		end
	end

	// Reset leaves the asynchronous select clear, so the I/O clock is the source. [R1]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_a_r  <= `TPC_RST_BYTE;
			wgm_top_r <= 1'b0;
			cs_r      <= `TPC_CS_STOP;
			cmp_a_r   <= `TPC_RST_BYTE;
			cmp_b_r   <= `TPC_RST_BYTE;
			external_clock_enable_r   <= 1'b0;
			async_r   <= 1'b0; // [R1]
		end else if (ce) begin
			ctrl_a_r  <= ctrl_a_nxt;
			wgm_top_r <= wgm_top_nxt;
			cs_r      <= cs_nxt;
			cmp_a_r   <= cmp_a_nxt;
			cmp_b_r   <= cmp_b_nxt;
			external_clock_enable_r   <= external_clock_enable_nxt;
			async_r   <= async_nxt;
		end
	end

	// Oscillator pin control: detach under async, crystal only without the external clock. [R3] [R4]
	assign osc_ctl.pins_detach    = async_r; // [R3]
	assign osc_ctl.crystal_enable = async_r & !external_clock_enable_r; // [R4]
	assign osc_ctl.ext_buf_enable = async_r & external_clock_enable_r; // [R4]

	// Two-flop synchroniser on the oscillator pin; the third flop only serves the edge detect.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end else if (ce) begin
			osc_s1_r <= timer_osc_in;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	// Source clock as a tick: every I/O clock, or each rising oscillator edge under async. [R1] [R2]
	assign src_tick = async_r ? (osc_s2_r & !osc_s3_r) : 1'b1; // [R2]

	tpc_prescaler #(
		.DIV_BITS (`TPC_DIV_BITS)
	) u_prescaler (
		.hclk               (hclk),
		.hresetn            (hresetn),
		.ce                 (ce),
		.src_tick           (src_tick),
		.psr                (psr),
		.clock_select_field (cs_r),
		.count_enable       (cnt_en)
	);

	// Waveform decode and TOP; reserved modes count as normal with non-PWM outputs. [R16]
	assign wgm      = tpc_wgm_t'({wgm_top_r, ctrl_a_r[`TPC_WGML_MSB:`TPC_WGML_LSB]});
	assign is_fast  = (wgm == WGM_FAST_FF) | (wgm == WGM_FAST_CMP); // [R16]
	assign is_phase = (wgm == WGM_PHASE_FF) | (wgm == WGM_PHASE_CMP); // [R16]
	assign top      = ((wgm == WGM_CTC) | (wgm == WGM_PHASE_CMP) | (wgm == WGM_FAST_CMP)) ? cmp_a_r : `TPC_MAX;
	assign at_top   = (cnt_r == top);

	// Counter: wraps after TOP, or runs up and down in phase-correct mode; a write blocks the next match.
	always_comb begin
		cnt_nxt   = cnt_r;
		up_nxt    = up_r;
		block_nxt = block_r;
		if (cnt_en) begin
			block_nxt = 1'b0;
			if (is_phase) begin
				if (up_r) begin
					up_nxt  = !at_top;
					cnt_nxt = at_top ? cnt_r - 8'h01 : cnt_r + 8'h01;
				end else begin
					up_nxt  = (cnt_r == `TPC_BOTTOM);
					cnt_nxt = up_nxt ? cnt_r + 8'h01 : cnt_r - 8'h01;
				end
			end else begin
				up_nxt  = 1'b1;
				cnt_nxt = at_top ? `TPC_BOTTOM : cnt_r + 8'h01;
			end
		end
		if (wr_do && (addr_r == `TPC_OFF_COUNT)) begin
			cnt_nxt   = hwdata[7:0];
			block_nxt = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r   <= `TPC_BOTTOM;
			up_r    <= 1'b1;
			block_r <= 1'b0;
		end else if (ce) begin
			cnt_r   <= cnt_nxt;
			up_r    <= up_nxt;
			block_r <= block_nxt;
		end
	end

	assign com[0]     = ctrl_a_r[`TPC_COMA_MSB:`TPC_COMA_LSB]; // [R7]
	assign com[1]     = ctrl_a_r[`TPC_COMB_MSB:`TPC_COMB_LSB]; // [R7]
	assign cmp[0]     = cmp_a_r;
	assign cmp[1]     = cmp_b_r;
	assign dir_bit[0] = dir_out_a;
	assign dir_bit[1] = dir_out_b;

	// One compare-output unit per channel; channel 0 is A, which alone may toggle in PWM modes.
	genvar gc;
	generate
		for (gc = 0; gc < 2; gc++) begin : g_chan
			logic match;
			logic special;
			logic may_toggle;

			assign match      = cnt_en & !block_r & (cnt_r == cmp[gc]);
			assign special    = com[gc][1] & (cmp[gc] == top); // [R12] [R15]
			assign may_toggle = (gc == 0) & wgm_top_r; // [R10] [R11] [R13] [R14]

			// Port override, except channel A code 01 in PWM without the top bit, which disconnects. [R8] [R10] [R13]
			assign ovr[gc] = (com[gc] != `TPC_COM_OFF) &
				!((gc == 0) & (is_fast | is_phase) & (com[gc] == `TPC_COM_TOGGLE) & !wgm_top_r); // [R8]

			// Output action per waveform family; BOTTOM and TOP actions follow the match so they win.
			always_comb begin
				oc_nxt[gc] = oc_r[gc];
				if (is_fast) begin
					if (match && !special) begin
						case (com[gc])
							`TPC_COM_TOGGLE: oc_nxt[gc] = may_toggle ? !oc_r[gc] : oc_r[gc]; // [R10] [R11]
							`TPC_COM_CLEAR:  oc_nxt[gc] = 1'b0; // [R10] [R11]
							`TPC_COM_SET:    oc_nxt[gc] = 1'b1; // [R10] [R11]
							default:         oc_nxt[gc] = oc_r[gc];
						endcase
					end
					if (cnt_en && at_top && com[gc][1]) begin
						oc_nxt[gc] = !com[gc][0]; // [R10] [R11] [R12]
					end
				end else if (is_phase) begin
					if (match && !special) begin
						case (com[gc])
							`TPC_COM_TOGGLE: oc_nxt[gc] = may_toggle ? !oc_r[gc] : oc_r[gc]; // [R13] [R14]
							`TPC_COM_CLEAR:  oc_nxt[gc] = !up_r; // [R13] [R14]
							`TPC_COM_SET:    oc_nxt[gc] = up_r; // [R13] [R14]
							default:         oc_nxt[gc] = oc_r[gc];
						endcase
					end
					if (special && cnt_en && at_top && up_r) begin
						oc_nxt[gc] = !com[gc][0]; // [R15]
					end
				end else if (match || force_cmp[gc]) begin
					case (com[gc])
						`TPC_COM_TOGGLE: oc_nxt[gc] = !oc_r[gc]; // [R9]
						`TPC_COM_CLEAR:  oc_nxt[gc] = 1'b0; // [R9]
						`TPC_COM_SET:    oc_nxt[gc] = 1'b1; // [R9]
						default:         oc_nxt[gc] = oc_r[gc]; // [R9]
					endcase
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					oc_r[gc] <= 1'b0;
				end else if (ce) begin
					oc_r[gc] <= oc_nxt[gc];
				end
			end
		end
	endgenerate

	// Pin view: the driver is enabled only when the override is on and direction is output. [R8]
	assign compare_out_a.value         = oc_r[0];
	assign compare_out_a.override_port = ovr[0];
	assign compare_out_a.oe            = ovr[0] & dir_bit[0]; // [R8]
	assign compare_out_b.value         = oc_r[1];
	assign compare_out_b.override_port = ovr[1];
	assign compare_out_b.oe            = ovr[1] & dir_bit[1]; // [R8]

endmodule : tpc_top

//--- test/tpc_checker.sv
// Purpose: Concurrent checks on the bus, pin and oscillator ports of the timer block.
// Assumes: hready is wired to hreadyout and ce stays high while requests are made.
// Notes:   Register contents are inferred from the bus traffic seen at the ports.
`timescale 1ns/1ps
`include "tpc_defines.svh"

module tpc_checker (
	input wire logic                  hclk,
	input wire logic                  hresetn,
	input wire logic                  ce,
	input wire logic                  hsel,
	input wire logic [31:0]           haddr,
	input wire logic [1:0]            htrans,
	input wire logic                  hwrite,
	input wire logic [31:0]           hwdata,
	input wire logic                  hready,
	input wire logic                  hreadyout,
	input wire logic [31:0]           hrdata,
	input wire logic                  hresp,
	input wire logic                  dir_out_a,
	input wire logic                  dir_out_b,
	input wire tpc_pkg::tpc_pin_t     compare_out_a,
	input wire tpc_pkg::tpc_pin_t     compare_out_b,
	input wire tpc_pkg::tpc_osc_ctl_t osc_ctl
);
	import tpc_pkg::*;
	logic tk;

	// A request counts only on a selected, ready and enabled edge.
	assign tk = hsel && htrans[1] && hready && ce;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_oe_dir_a: assert property (compare_out_a.oe == (compare_out_a.override_port && dir_out_a))
		else $error("pin a enable does not follow override and direction");
	a_oe_dir_b: assert property (compare_out_b.oe == (compare_out_b.override_port && dir_out_b))
		else $error("pin b enable does not follow override and direction");
	a_osc_pin_coding: assert property (osc_ctl.pins_detach == (osc_ctl.crystal_enable ^ osc_ctl.ext_buf_enable))
		else $error("oscillator controls inconsistent");
	a_read_one_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_no_wait: assert property (tk && hwrite |=> hreadyout && !hresp)
		else $error("write stalled or not okay");
	a_ctrl_a_rsvd: assert property (tk && !hwrite && haddr == `TPC_OFF_CTRL_A |=> ##1
		(hrdata[31:8] == 24'h0 && hrdata[3:2] == 2'h0)) else $error("control a reserved bits not zero");
	a_status_source: assert property (tk && hwrite && haddr == `TPC_OFF_ASYNC_STAT |=> ##1
		(osc_ctl.pins_detach == $past(hwdata[5]) && osc_ctl.ext_buf_enable == $past(hwdata[6] && hwdata[5])))
		else $error("clock source controls do not follow status write");
	a_override_a: assert property (tk && hwrite && haddr == `TPC_OFF_CTRL_A |=> ##1
		(compare_out_a.override_port == $past(hwdata[7]) || $past(hwdata[7:6]) == 2'h1))
		else $error("pin a override wrong");
	a_override_b: assert property (tk && hwrite && haddr == `TPC_OFF_CTRL_A |=> ##1
		(compare_out_b.override_port == (|$past(hwdata[5:4])))) else $error("pin b override wrong");
	a_hold_b_off: assert property (!compare_out_b.override_port && !$past(compare_out_b.override_port)
		|-> $stable(compare_out_b.value)) else $error("pin b changed while disconnected");

	// Coverage of the main traffic and waveform activity.
	c_read: cover property (tk && !hwrite);
	c_detach: cover property ($rose(osc_ctl.pins_detach));
	c_wave_a: cover property ($rose(compare_out_a.value));
endmodule : tpc_checker

//--- test/tpc_pin_model.sv
// Purpose: Port pads with pull-ups and an applied oscillator clock for the timer block.
// Assumes: The bench calls burst to deliver a known number of oscillator edges.
// Notes:   The half period is a scaled stand-in, kept well below a quarter of hclk.
`timescale 1ns/1ps

module tpc_pin_model #(
	parameter int HALF_NS = 250
) (
	output logic                  osc,
	input  wire tpc_pkg::tpc_pin_t pin_a,
	input  wire tpc_pkg::tpc_pin_t pin_b,
	output logic                  pad_a,
	output logic                  pad_b
);
	import tpc_pkg::*;

	// The pads are pulled up, so a pad nobody drives reads high instead of a stale value.
	assign pad_a = pin_a.oe ? pin_a.value : 1'b1;
	assign pad_b = pin_b.oe ? pin_b.value : 1'b1;

	initial osc = 1'b0;

	// The applied clock rests low between bursts so the edge count is exact.
	task burst(input int n);
		#(HALF_NS / 2); // Keeps pin edges off the hclk rising edge, so sampling is not a race.
		repeat (n) begin
			#(HALF_NS) osc = 1'b1;
			#(HALF_NS) osc = 1'b0;
		end
	endtask : burst
endmodule : tpc_pin_model

//--- test/tpc_top_tb.sv
// Purpose: Self-checking bench for the timer prescaler and compare-output block.
// Assumes: One AHB-Lite master; the pin model supplies pads and the oscillator pin.
// Notes:   Duty counts span whole waveform periods, so the start phase cannot matter.
`timescale 1ns/1ps
`include "tpc_defines.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end

module tpc_top_tb;
	import tpc_pkg::*;
	logic         hclk = 1'b0;
	logic         hresetn = 1'b0;
	logic         ce = 1'b1;
	logic         hsel = 1'b0;
	logic [31:0]  haddr = 32'h0;
	logic [1:0]   htrans = 2'h0;
	logic         hwrite = 1'b0;
	logic [31:0]  hwdata = 32'h0;
	logic         hreadyout;
	logic         hresp;
	logic [31:0]  hrdata;
	logic         dir_a = 1'b0;
	logic         dir_b = 1'b0;
	logic         osc;
	logic         pad_a;
	logic         pad_b;
	logic         rd_ph = 1'b0;
	tpc_pin_t     pin_a;
	tpc_pin_t     pin_b;
	tpc_osc_ctl_t oc;
	logic [31:0]  exq[$];
	logic [31:0]  ex;
	logic [31:0]  v;
	logic [1:0]   cd[5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h1};
	logic [4:0]   ev = 5'b01101;
	int           dv[6] = '{8, 32, 64, 128, 256, 1024};
	int           fails = 0;
	int           n_compared = 0;
	int           seed = 12;

	always #25 hclk = ~hclk;

	tpc_top DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .timer_osc_in(osc), .dir_out_a(dir_a), .dir_out_b(dir_b),
		.compare_out_a(pin_a), .compare_out_b(pin_b), .osc_ctl(oc));
	tpc_pin_model u_pins (.osc(osc), .pin_a(pin_a), .pin_b(pin_b), .pad_a(pad_a), .pad_b(pad_b));

	// One single transfer; each phase is held until hready is seen high at an edge.
	task bus(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : bus

	task rd(input logic [31:0] a, e);
		exq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd

	// Program a waveform, let it settle for a full period, then count high pad cycles.
	task pw(input logic [2:0] wg, input logic [1:0] ca, cb, input logic [7:0] xa, xb, input int n, ea, eb);
		logic [15:0] ha;
		logic [15:0] hb;
		bus(1'b1, `TPC_OFF_CTRL_B, {28'h0, wg[2], 3'h1});
		bus(1'b1, `TPC_OFF_CTRL_A, {24'h0, ca, cb, 2'h0, wg[1:0]});
		bus(1'b1, `TPC_OFF_CMP_A, {24'h0, xa});
		bus(1'b1, `TPC_OFF_CMP_B, {24'h0, xb});
		repeat (600) @(posedge hclk);
		ha = 16'h0;
		hb = 16'h0;
		repeat (n) begin
			@(posedge hclk);
			ha += 16'(pad_a);
			hb += 16'(pad_b);
		end
		`CHK(ha, 16'(ea))
		`CHK(hb, 16'(eb))
	endtask : pw

	task tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	// Read data is taken at the edge that ends the data phase and matched to the oldest note.
	always @(posedge hclk) begin
		if (rd_ph && hreadyout) begin
			rd_ph <= 1'b0;
			ex = exq.pop_front();
			`CHK(hrdata, ex)
		end
		if (hsel && htrans[1] && hreadyout && !hwrite) rd_ph <= 1'b1;
	end

	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int a = 'hb0; a <= 'hc8; a += 4) rd(32'(a), 32'h0);
		rd(32'h100, 32'h0);
		`CHK(oc, 3'b000)
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			bus(1'b1, `TPC_OFF_CTRL_A, v);
			rd(`TPC_OFF_CTRL_A, v & 32'hf3);
			bus(1'b1, `TPC_OFF_CMP_B, v);
			rd(`TPC_OFF_CMP_B, v & 32'hff);
			bus(1'b1, 32'h100, v);
			rd(32'h100, 32'h0);
		end
		$display("test registers done");
		bus(1'b1, `TPC_OFF_CMP_A, 32'h80);
		bus(1'b1, `TPC_OFF_CMP_B, 32'h80);
		bus(1'b1, `TPC_OFF_CTRL_A, 32'h40);
		@(posedge hclk);
		`CHK({pin_a.override_port, pin_a.oe, pad_a, pin_b.override_port}, 4'b1010)
		dir_a <= 1'b1;
		dir_b <= 1'b1;
		@(posedge hclk);
		`CHK({pin_a.oe, pad_a, pin_b.oe, pad_b}, 4'b1001)
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, `TPC_OFF_CTRL_A, {24'h0, cd[i], cd[i], 4'h0});
			bus(1'b1, `TPC_OFF_CTRL_B, 32'hc0);
			@(posedge hclk);
			`CHK({pin_a.value, pin_b.value}, {2{ev[i]}})
		end
		bus(1'b1, `TPC_OFF_CTRL_A, 32'hf0);
		bus(1'b1, `TPC_OFF_CTRL_B, 32'h01);
		repeat (300) @(posedge hclk);
		`CHK({pin_a.value, pin_b.value}, 2'b11)
		$display("test non-pwm outputs done");
		bus(1'b1, `TPC_OFF_CTRL_B, 32'h00);
		bus(1'b1, `TPC_OFF_COUNT, 32'h55);
		repeat (100) @(posedge hclk);
		rd(`TPC_OFF_COUNT, 32'h55);
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, `TPC_OFF_COUNT, 32'h0);
			bus(1'b1, `TPC_OFF_GEN_CTRL, 32'h2);
			bus(1'b1, `TPC_OFF_CTRL_B, 32'(i + 2));
			repeat (dv[i] * 3 + dv[i] / 4) @(posedge hclk);
			rd(`TPC_OFF_COUNT, 32'h3);
			bus(1'b1, `TPC_OFF_CTRL_B, 32'h0);
		end
		$display("test prescaler done");
		bus(1'b1, `TPC_OFF_ASYNC_STAT, 32'h20);
		bus(1'b1, `TPC_OFF_CTRL_B, 32'h01);
		bus(1'b1, `TPC_OFF_COUNT, 32'h0);
		repeat (40) @(posedge hclk);
		rd(`TPC_OFF_COUNT, 32'h0);
		`CHK(oc, 3'b110)
		u_pins.burst(5);
		repeat (10) @(posedge hclk);
		rd(`TPC_OFF_COUNT, 32'h5);
		bus(1'b1, `TPC_OFF_ASYNC_STAT, 32'h60);
		@(posedge hclk);
		`CHK(oc, 3'b101)
		bus(1'b1, `TPC_OFF_ASYNC_STAT, 32'h0);
		$display("test clock source done");
		pw(3'h3, 2'h2, 2'h2, 8'h40, 8'h20, 512, 130, 66);
		pw(3'h3, 2'h3, 2'h3, 8'h40, 8'h20, 512, 382, 446);
		pw(3'h3, 2'h2, 2'h3, 8'hff, 8'hff, 512, 512, 0);
		pw(3'h7, 2'h1, 2'h2, 8'h3f, 8'h10, 512, 256, 136);
		pw(3'h1, 2'h2, 2'h2, 8'h40, 8'h20, 1020, 256, 128);
		pw(3'h1, 2'h3, 2'h3, 8'h40, 8'h20, 1020, 764, 892);
		pw(3'h1, 2'h2, 2'h3, 8'hff, 8'hff, 1020, 1020, 0);
		pw(3'h5, 2'h1, 2'h2, 8'h40, 8'h10, 1024, 512, 256);
		bus(1'b1, `TPC_OFF_CTRL_B, 32'h0);
		bus(1'b1, `TPC_OFF_CTRL_A, 32'h53);
		@(posedge hclk);
		`CHK({pin_a.override_port, pin_b.override_port}, 2'b01)
		bus(1'b1, `TPC_OFF_CTRL_A, 32'h41);
		@(posedge hclk);
		`CHK({pin_a.override_port, pin_b.override_port}, 2'b00)
		bus(1'b1, `TPC_OFF_CTRL_A, 32'h02);
		bus(1'b1, `TPC_OFF_COUNT, 32'h3f);
		bus(1'b1, `TPC_OFF_CTRL_B, 32'h01);
		bus(1'b1, `TPC_OFF_CTRL_B, 32'h00);
		rd(`TPC_OFF_COUNT, 32'h0);
		$display("test pwm outputs done");
		tally_and_finish();
	end

	// A hang past the expected run length counts as a mismatch.
	initial begin
		repeat (50000) @(posedge hclk);
		fails++;
		tally_and_finish();
	end
endmodule : tpc_top_tb

bind tpc_top tpc_checker u_chk (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.hreadyout, .hrdata, .hresp, .dir_out_a, .dir_out_b, .compare_out_a, .compare_out_b, .osc_ctl);
